// File: design/shbp_pkg.sv
// constants, states and timing counts shared by both ends of the host port
// assumes one 125 MHz clock on both ends; all times derive from its period
//
// Functional notes
// - read runs while select and read strobe low
// - write runs while select and write strobe low
// - host read: 45 cycle, 32 low, 13 high
// - read data by 30 ns, released after; the device end drives it 5 cycles (40 ns) after select and read strobe fall
// - host write: 45 cycle, 32 low, 13 high
// - ordinary burst: 8 dwords or 16 words
// - burst address held 45 ns, data 40 ns
// - strobes high 13 ns between bursts
// - 16-bit mode: upper data lines never driven; the host end still drives them during writes
// - 16-bit mode: upper data ignored on writes
// - fifo select reads receive fifo, any address
// - fifo mode keeps A[2:1], drops A[7:3]
// - fifo select held stable like address lines
// - fifo direct burst has no beat limit
// - direct burst gaps at least 13 ns
// - only single writes, no burst writes
// - read value latched at access start
package shbp_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int T_CYCLE_NS = 45;
	localparam int T_CSL_NS = 32;
	localparam int T_CSH_NS = 13;
	localparam int T_CSDV_NS = 30;
	localparam int T_ACYC_NS = 45;
	localparam int T_ADV_NS = 40;

	// least time: round up; at least one cycle
	function automatic int min_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// longest time: round down; at least one cycle
	function automatic int max_cyc(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int CYCLE_CYC = min_cyc(T_CYCLE_NS);
	localparam int CSL_CYC = min_cyc(T_CSL_NS);
	localparam int CSH_CYC = min_cyc(T_CSH_NS);
	localparam int ACYC_CYC = min_cyc(T_ACYC_NS);
	localparam int CSDV_CYC = max_cyc(T_CSDV_NS);
	localparam int ADV_CYC = max_cyc(T_ADV_NS);

	localparam int SYNC_STAGES = 3;
	// device answer plus host resampling, measured from strobe edge;
	// the host trusts data only once its second and third stages agree
	localparam int RSP_LAT_CYC = 2 * SYNC_STAGES + 3;
	localparam int RD_HOLD_CYC = (RSP_LAT_CYC > CSL_CYC) ?
		RSP_LAT_CYC : CSL_CYC;
	localparam int BEAT_CYC = (RD_HOLD_CYC > ACYC_CYC) ?
		RD_HOLD_CYC : ACYC_CYC;
	localparam int WR_LOW_CYC = (CYCLE_CYC - CSH_CYC > CSL_CYC) ?
		CYCLE_CYC - CSH_CYC : CSL_CYC;
	localparam int WR_GAP_CYC = CSH_CYC;
	// after a read the device lets go of the data lines late
	localparam int RD_GAP_CYC = (SYNC_STAGES + 2 > CSH_CYC) ?
		SYNC_STAGES + 2 : CSH_CYC;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BURST_DWORDS = 8;
	localparam int BURST_WORDS = 16;
	localparam int BEAT_CNT_W = 5;

	// pin bundle layout as sampled by the device
	localparam int PIN_ADDR_LSB = 32;
	localparam int PIN_FIFO = 39;
	localparam int PIN_WR = 40;
	localparam int PIN_RD = 41;
	localparam int PIN_CS = 42;
	localparam int PIN_W = 43;
	localparam int FIFO_KEEP_W = 2;

	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h1,
		DEV_READ = 3'h2,
		DEV_WRITE = 3'h4
	} shbp_dev_st_t;

	typedef enum logic [3:0] {
		HST_IDLE = 4'h1,
		HST_READ = 4'h2,
		HST_WRITE = 4'h4,
		HST_GAP = 4'h8
	} shbp_hst_st_t;

endpackage

// File: design/shbp_if.sv
// pin-level bus between the host end and the device end
// resolves the shared data lines from both enables; idle lines read high
`timescale 1ns/1ps
interface shbp_if;
	logic chip_select_n;
	logic read_strobe_n;
	logic write_strobe_n;
	logic fifo_sel;
	logic [shbp_pkg::ADDR_W-1:0] addr;
	logic [shbp_pkg::DATA_W-1:0] host_data;
	logic host_data_oe;
	logic [shbp_pkg::DATA_W-1:0] dev_data;
	logic [1:0] dev_data_oe;
	logic [shbp_pkg::DATA_W-1:0] bus_data;

	// each half driven by whichever end enables it, else pulled high
	assign bus_data[15:0] = dev_data_oe[0] ? dev_data[15:0] :
		host_data_oe ? host_data[15:0] : 16'hffff;
	assign bus_data[31:16] = dev_data_oe[1] ? dev_data[31:16] :
		host_data_oe ? host_data[31:16] : 16'hffff;

	modport dev_mp (
		input chip_select_n,
		input read_strobe_n,
		input write_strobe_n,
		input fifo_sel,
		input addr,
		input bus_data,
		output dev_data,
		output dev_data_oe
	);

	modport host_mp (
		output chip_select_n,
		output read_strobe_n,
		output write_strobe_n,
		output fifo_sel,
		output addr,
		output host_data,
		output host_data_oe,
		input bus_data
	);
endinterface

// File: design/shbp_sync.sv
// three-stage pin synchroniser; exposes second and third stages
// assumes the caller only trusts a value once both stages agree
`timescale 1ns/1ps
module shbp_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] s2_o,
	output logic [W-1:0] s3_o
);
	logic [W-1:0] s1_q;

	// first stage feeds only the second
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s1_q <= '1;
			s2_o <= '1;
			s3_o <= '1;
		end
		else
		begin
			s1_q <= async_i;
			s2_o <= s1_q;
			s3_o <= s2_o;
		end
	end
endmodule

// File: design/shbp_device.sv
// device end of the sram-like host port: reads, bursts, fifo reads, writes
// assumes user logic answers reg_rdata_i from reg_addr_o in the same cycle
// and presents the receive fifo head on fifo_rdata_i
`timescale 1ns/1ps
module shbp_device (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	shbp_if.dev_mp bus,
	input wire logic bus16_i,
	output logic [shbp_pkg::ADDR_W-1:0] reg_addr_o,
	output logic acc_fifo_o,
	output logic reg_rd_o,
	input wire logic [shbp_pkg::DATA_W-1:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic [shbp_pkg::DATA_W-1:0] reg_wdata_o,
	output logic fifo_pop_o,
	input wire logic [shbp_pkg::DATA_W-1:0] fifo_rdata_i,
	output logic burst_overrun_o
);
	localparam int PW = shbp_pkg::PIN_W;
	localparam int AW = shbp_pkg::ADDR_W;
	localparam int DW = shbp_pkg::DATA_W;
	localparam int HW = shbp_pkg::HALF_W;
	localparam int BW = shbp_pkg::BEAT_CNT_W;

	logic [PW-1:0] pins;
	logic [PW-1:0] s2;
	logic [PW-1:0] s3;
	shbp_pkg::shbp_dev_st_t st_q;
	logic load_q;
	logic [BW-1:0] beats_q;
	logic rd_on;
	logic rd_off;
	logic wr_on;
	logic wr_off;
	logic addr_stable;
	logic fifo_s;
	logic [AW-1:0] eff_addr;
	logic new_beat;
	logic at_limit;
	logic [BW-1:0] limit;
	logic [DW-1:0] src;

	// read access seen on one pipeline stage
	function automatic logic rd_act(input logic [PW-1:0] v);
		return !v[shbp_pkg::PIN_CS] && !v[shbp_pkg::PIN_RD];
	endfunction

	// write access seen on one pipeline stage
	function automatic logic wr_act(input logic [PW-1:0] v);
		return !v[shbp_pkg::PIN_CS] && !v[shbp_pkg::PIN_WR];
	endfunction

	function automatic logic [AW-1:0] addr_of(input logic [PW-1:0] v);
		return v[shbp_pkg::PIN_ADDR_LSB +: AW];
	endfunction

	assign pins = {bus.chip_select_n, bus.read_strobe_n,
		bus.write_strobe_n, bus.fifo_sel, bus.addr, bus.bus_data};

	shbp_sync #(
		.W(PW)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.async_i(pins),
		.s2_o(s2),
		.s3_o(s3)
	);

	// a strobe change counts once stages two and three agree
	assign rd_on = rd_act(s2) && rd_act(s3);
	assign rd_off = !rd_act(s2) && !rd_act(s3);
	assign wr_on = wr_act(s2) && wr_act(s3);
	assign wr_off = !wr_act(s2) && !wr_act(s3);
	// address and fifo select only; the data lines move during reads
	assign addr_stable = (s2[shbp_pkg::PIN_FIFO:shbp_pkg::PIN_ADDR_LSB] ==
		s3[shbp_pkg::PIN_FIFO:shbp_pkg::PIN_ADDR_LSB]);
	assign fifo_s = s3[shbp_pkg::PIN_FIFO];

	// fifo select drops the upper address, keeps word select
	assign eff_addr = fifo_s ?
		{{(AW - shbp_pkg::FIFO_KEEP_W){1'b0}},
		s3[shbp_pkg::PIN_ADDR_LSB +: shbp_pkg::FIFO_KEEP_W]} :
		addr_of(s3);

	// burst beat limit depends on width; fifo bursts are unlimited
	assign limit = bus16_i ? BW'(shbp_pkg::BURST_WORDS) :
		BW'(shbp_pkg::BURST_DWORDS);
	assign at_limit = !acc_fifo_o && (beats_q == limit);
	assign new_beat = (st_q == shbp_pkg::DEV_READ) && rd_on &&
		addr_stable && !load_q &&
		((eff_addr != reg_addr_o) || (fifo_s != acc_fifo_o));
	assign src = acc_fifo_o ? fifo_rdata_i : reg_rdata_i;

	// access state: idle, read (single or burst), single write
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_q <= shbp_pkg::DEV_IDLE;
		else
		begin
			case (st_q)
				shbp_pkg::DEV_IDLE:
				begin
					if (rd_on && addr_stable)
						st_q <= shbp_pkg::DEV_READ;
					else if (wr_on && addr_stable)
						st_q <= shbp_pkg::DEV_WRITE;
				end
				shbp_pkg::DEV_READ:
				begin
					if (rd_off)
						st_q <= shbp_pkg::DEV_IDLE;
				end
				shbp_pkg::DEV_WRITE:
				begin
					if (wr_off)
						st_q <= shbp_pkg::DEV_IDLE;
				end
				default:
					st_q <= shbp_pkg::DEV_IDLE;
			endcase
		end
	end

	// access address and target, taken at start and at each new beat within the limit
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reg_addr_o <= shbp_pkg::ADDR_RST;
			acc_fifo_o <= 1'b0;
		end
		else if ((st_q == shbp_pkg::DEV_IDLE && (rd_on || wr_on) &&
			addr_stable) || (new_beat && !at_limit))
		begin
			reg_addr_o <= eff_addr;
			acc_fifo_o <= fifo_s;
		end
	end

	// load strobe: one cycle after the address is set, data is captured
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			load_q <= 1'b0;
			reg_rd_o <= 1'b0;
		end
		else
		begin
			load_q <= (st_q == shbp_pkg::DEV_IDLE && rd_on &&
				addr_stable) || (new_beat && !at_limit);
			reg_rd_o <= ((st_q == shbp_pkg::DEV_IDLE && rd_on &&
				addr_stable && !fifo_s) ||
				(new_beat && !at_limit && !fifo_s));
		end
	end

	// beat count within one read access; flags beats past the limit
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			beats_q <= '0;
			burst_overrun_o <= 1'b0;
		end
		else if (st_q != shbp_pkg::DEV_READ)
		begin
			beats_q <= BW'(1);
			burst_overrun_o <= 1'b0;
		end
		else if (new_beat)
		begin
			if (at_limit)
				burst_overrun_o <= 1'b1;
			else if (!acc_fifo_o)
				beats_q <= beats_q + BW'(1);
		end
	end

	// read data held stable for the whole beat; upper half off in 16-bit
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bus.dev_data <= shbp_pkg::DATA_RST;
			bus.dev_data_oe <= 2'h0;
		end
		else if (st_q == shbp_pkg::DEV_READ && rd_off)
			bus.dev_data_oe <= 2'h0;
		else if (load_q && st_q == shbp_pkg::DEV_READ)
		begin
			bus.dev_data <= bus16_i ? {{HW{1'b0}}, src[HW-1:0]} :
				src;
			bus.dev_data_oe <= {!bus16_i, 1'b1};
		end
	end

	// pop the receive fifo as each fifo beat latches its word, so the
	// next beat loads the new head rather than the stale one
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			fifo_pop_o <= 1'b0;
		else
			fifo_pop_o <= (st_q == shbp_pkg::DEV_READ) && acc_fifo_o &&
				load_q && !rd_off;
	end

	// write data follows the pins while the write runs; last value kept
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			reg_wdata_o <= shbp_pkg::DATA_RST;
			reg_wr_o <= 1'b0;
		end
		else
		begin
			reg_wr_o <= (st_q == shbp_pkg::DEV_WRITE) && wr_off;
			if (st_q == shbp_pkg::DEV_WRITE && wr_on)
				reg_wdata_o <= bus16_i ?
					{{HW{1'b0}}, s3[HW-1:0]} : s3[DW-1:0];
		end
	end
endmodule

// File: design/shbp_host.sv
// host end of the sram-like port: turns commands into strobed cycles
// assumes one command at a time; read data returned per beat
`timescale 1ns/1ps
module shbp_host #(
	parameter int BEATS_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	shbp_if.host_mp bus,
	input wire logic bus16_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic cmd_fifo_i,
	input wire logic [shbp_pkg::ADDR_W-1:0] cmd_addr_i,
	input wire logic [BEATS_W-1:0] cmd_beats_i,
	input wire logic [shbp_pkg::DATA_W-1:0] cmd_wdata_i,
	output logic rsp_valid_o,
	output logic rsp_last_o,
	output logic [shbp_pkg::DATA_W-1:0] rsp_data_o
);
	localparam int AW = shbp_pkg::ADDR_W;
	localparam int DW = shbp_pkg::DATA_W;
	localparam int CW = 4;

	shbp_pkg::shbp_hst_st_t st_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] gap_q;
	logic [BEATS_W-1:0] left_q;
	logic [BEATS_W-1:0] lim;
	logic [BEATS_W-1:0] req;
	logic [DW-1:0] d2;
	logic [DW-1:0] d3;
	logic take;

	shbp_sync #(
		.W(DW)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.async_i(bus.bus_data),
		.s2_o(d2),
		.s3_o(d3)
	);

	assign take = cmd_valid_i && cmd_ready_o;
	assign lim = bus16_i ? BEATS_W'(shbp_pkg::BURST_WORDS) :
		BEATS_W'(shbp_pkg::BURST_DWORDS);
	// ordinary bursts are clipped; fifo bursts are not
	assign req = (cmd_beats_i == '0) ? BEATS_W'(1) :
		(!cmd_fifo_i && cmd_beats_i > lim) ? lim :
		cmd_beats_i;

	// cycle sequencer and strobe pins
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_q <= shbp_pkg::HST_IDLE;
			cnt_q <= '0;
			gap_q <= '0;
			left_q <= '0;
			cmd_ready_o <= 1'b1;
			bus.chip_select_n <= 1'b1;
			bus.read_strobe_n <= 1'b1;
			bus.write_strobe_n <= 1'b1;
			bus.fifo_sel <= 1'b0;
			bus.addr <= shbp_pkg::ADDR_RST;
			bus.host_data <= shbp_pkg::DATA_RST;
			bus.host_data_oe <= 1'b0;
		end
		else
		begin
			case (st_q)
				shbp_pkg::HST_IDLE:
				begin
					cnt_q <= '0;
					if (take)
					begin
						cmd_ready_o <= 1'b0;
						bus.chip_select_n <= 1'b0;
						bus.fifo_sel <= cmd_fifo_i;
						bus.addr <= cmd_addr_i;
						left_q <= req;
						if (cmd_write_i)
						begin
							st_q <= shbp_pkg::HST_WRITE;
							bus.write_strobe_n <= 1'b0;
							bus.host_data <= cmd_wdata_i;
							bus.host_data_oe <= 1'b1;
						end
						else
						begin
							st_q <= shbp_pkg::HST_READ;
							bus.read_strobe_n <= 1'b0;
						end
					end
				end
				shbp_pkg::HST_READ:
				begin
					cnt_q <= cnt_q + CW'(1);
					if (cnt_q == CW'(shbp_pkg::BEAT_CYC - 1))
					begin
						cnt_q <= '0;
						if (left_q == BEATS_W'(1))
						begin
							st_q <= shbp_pkg::HST_GAP;
							gap_q <= CW'(shbp_pkg::RD_GAP_CYC - 1);
							bus.chip_select_n <= 1'b1;
							bus.read_strobe_n <= 1'b1;
						end
						else
						begin
							left_q <= left_q - BEATS_W'(1);
							bus.addr <= bus.addr +
								(bus16_i ? AW'(1) : AW'(2));
						end
					end
				end
				shbp_pkg::HST_WRITE:
				begin
					cnt_q <= cnt_q + CW'(1);
					if (cnt_q == CW'(shbp_pkg::WR_LOW_CYC - 1))
					begin
						cnt_q <= '0;
						st_q <= shbp_pkg::HST_GAP;
						gap_q <= CW'(shbp_pkg::WR_GAP_CYC - 1);
						bus.chip_select_n <= 1'b1;
						bus.write_strobe_n <= 1'b1;
					end
				end
				shbp_pkg::HST_GAP:
				begin
					bus.host_data_oe <= 1'b0;
					cnt_q <= cnt_q + CW'(1);
					if (cnt_q == gap_q)
					begin
						cnt_q <= '0;
						st_q <= shbp_pkg::HST_IDLE;
						cmd_ready_o <= 1'b1;
					end
				end
				default:
					st_q <= shbp_pkg::HST_IDLE;
			endcase
		end
	end

	// answer per read beat, sampled at the end of the beat
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_last_o <= 1'b0;
			rsp_data_o <= shbp_pkg::DATA_RST;
		end
		else
		begin
			rsp_valid_o <= 1'b0;
			rsp_last_o <= 1'b0;
			if (st_q == shbp_pkg::HST_READ &&
				cnt_q == CW'(shbp_pkg::BEAT_CYC - 1) && d2 == d3)
			begin
				rsp_valid_o <= 1'b1;
				rsp_last_o <= (left_q == BEATS_W'(1));
				rsp_data_o <= bus16_i ?
					{{shbp_pkg::HALF_W{1'b0}},
					d3[shbp_pkg::HALF_W-1:0]} : d3;
			end
		end
	end
endmodule

// File: sim/shbp_chk.sv
// pin-level checks on the link between host end and device end
// assumes it is instantiated beside the interface, one clock domain
`timescale 1ns/1ps
module shbp_chk (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic bus16_i,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic fifo_sel,
	input wire logic [shbp_pkg::ADDR_W-1:0] addr,
	input wire logic [shbp_pkg::DATA_W-1:0] host_data,
	input wire logic host_data_oe,
	input wire logic [shbp_pkg::DATA_W-1:0] dev_data,
	input wire logic [1:0] dev_data_oe,
	input wire logic [shbp_pkg::DATA_W-1:0] bus_data
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic rd_act;
	logic wr_act;
	// combined strobes: an access runs only while select and strobe are low
	assign rd_act = !chip_select_n && !read_strobe_n;
	assign wr_act = !chip_select_n && !write_strobe_n;

	property p_oe_idle;
		!rd_act [*5] |-> dev_data_oe == 2'b00;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("device drives data lines outside a read");
	property p_data_on;
		$rose(rd_act) |-> ##[1:5] dev_data_oe[0];
	endproperty
	a_data_on: assert property (p_data_on)
		else $error("read data not driven in time");
	property p_upper16;
		bus16_i |-> !dev_data_oe[1];
	endproperty
	a_upper16: assert property (p_upper16)
		else $error("upper data lines driven in 16-bit mode");
	property p_upper32;
		!bus16_i && dev_data_oe[0] |-> dev_data_oe[1];
	endproperty
	a_upper32: assert property (p_upper32)
		else $error("upper half not driven in 32-bit read");
	property p_contend;
		host_data_oe |-> dev_data_oe == 2'b00;
	endproperty
	a_contend: assert property (p_contend)
		else $error("both ends drive the data lines");
	property p_wr_low;
		$fell(write_strobe_n) |-> !write_strobe_n [*4];
	endproperty
	a_wr_low: assert property (p_wr_low)
		else $error("write strobe low too briefly");
	property p_gap;
		$fell(rd_act || wr_act) |-> !(rd_act || wr_act) [*2];
	endproperty
	a_gap: assert property (p_gap)
		else $error("strobes high too briefly between accesses");
	property p_addr_hold;
		rd_act && $changed(addr) |=> $stable(addr) [*5];
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("burst address held too briefly");
	property p_fifo_stable;
		rd_act && $past(rd_act) |-> $stable(fifo_sel);
	endproperty
	a_fifo_stable: assert property (p_fifo_stable)
		else $error("fifo select changed inside a read");
	property p_wr_hold;
		wr_act && $past(wr_act) |->
			$stable(host_data) && $stable(addr) && host_data_oe;
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data or address moved during write");
endmodule

// File: sim/test_sram_like_host_bus_port.sv
// self-checking bench joining the host end and device end of the port
// assumes package and interface compiled first; one 125 MHz clock
`timescale 1ns/1ps
module test_sram_like_host_bus_port;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic bus16 = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic cmd_fifo = 1'b0;
	logic [6:0] cmd_addr = 7'h00;
	logic [7:0] cmd_beats = 8'h00;
	logic [31:0] cmd_wdata = 32'h0000_0000;
	logic cmd_ready, rsp_valid, rsp_last, acc_fifo, reg_rd, reg_wr;
	logic fifo_pop, overrun, exp_fifo;
	logic [31:0] rsp_data, reg_rdata, reg_wdata, fifo_rdata, exp_wdata;
	logic [31:0] fcnt = 32'h0;
	logic [31:0] seed = 32'h2eaa;
	logic [6:0] reg_addr, exp_addr;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_wr = 0;
	int ov_cnt = 0;

	shbp_if link ();
	shbp_device shbp_device_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.bus(link), .bus16_i(bus16), .reg_addr_o(reg_addr),
		.acc_fifo_o(acc_fifo), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata),
		.reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .fifo_pop_o(fifo_pop),
		.fifo_rdata_i(fifo_rdata), .burst_overrun_o(overrun));
	shbp_host shbp_host_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.bus(link), .bus16_i(bus16), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write),
		.cmd_fifo_i(cmd_fifo), .cmd_addr_i(cmd_addr), .cmd_beats_i(cmd_beats),
		.cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
		.rsp_last_o(rsp_last), .rsp_data_o(rsp_data));
	shbp_chk shbp_chk_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.bus16_i(bus16), .chip_select_n(link.chip_select_n),
		.read_strobe_n(link.read_strobe_n),
		.write_strobe_n(link.write_strobe_n), .fifo_sel(link.fifo_sel),
		.addr(link.addr), .host_data(link.host_data),
		.host_data_oe(link.host_data_oe), .dev_data(link.dev_data),
		.dev_data_oe(link.dev_data_oe), .bus_data(link.bus_data));

	// halves equal so either half selection yields the same word
	function automatic logic [31:0] reg_val(input logic [6:0] a);
		return {2{1'b0, a, ~{1'b0, a}}};
	endfunction
	function automatic logic [31:0] fifo_val(input logic [31:0] i);
		return {2{i[7:0] ^ 8'h5a, ~i[7:0]}};
	endfunction
	// expected beat: register or fifo word, zero-extended in 16-bit mode
	function automatic logic [31:0] beat_val(input logic f, b16,
		input logic [6:0] a, input logic [31:0] base, input int k);
		logic [31:0] v;
		v = f ? fifo_val(base + k) : reg_val(a + 7'(b16 ? k : 2 * k));
		return b16 ? {16'h0, v[15:0]} : v;
	endfunction
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_data({31'h0, got}, {31'h0, exp});
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one command through the host end, beats checked as they return
	task automatic run(input logic wr, f, input logic [6:0] a,
		input logic [7:0] nb, input logic [31:0] wd);
		int n, got, w, ov0, wr0, lim;
		logic [31:0] base;
		#1;
		n = (nb == 8'h00) ? 1 : int'(nb);
		lim = f ? 100000 : (bus16 ? 16 : 8);
		// the host end clips an ordinary burst to its beat limit
		if (!wr && !f && n > lim)
			n = lim;
		got = 0;
		ov0 = ov_cnt;
		wr0 = n_wr;
		base = fcnt;
		exp_fifo = f;
		exp_addr = a;
		exp_wdata = bus16 ? {16'h0, wd[15:0]} : wd;
		@(posedge ref_clk_i);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_fifo <= f;
		cmd_addr <= a;
		cmd_beats <= nb;
		cmd_wdata <= wd;
		do @(posedge ref_clk_i); while (!cmd_ready);
		cmd_valid <= 1'b0;
		for (w = 0; w < 400; w++)
		begin
			@(posedge ref_clk_i);
			if (rsp_valid && got < lim)
				chk_data(rsp_data, beat_val(f, bus16, a, base, got));
			if (rsp_valid)
				chk_bit(rsp_last, got == n - 1);
			if (rsp_valid)
				got++;
			if (cmd_ready && (wr ? n_wr != wr0 : got == n))
				break;
		end
		if (w == 400)
			n_mismatch++;
		chk_bit(ov_cnt != ov0, !wr && !f && n > lim);
		chk_data(fcnt - base, (f && !wr) ? n : 0);
	endtask

	// user side of the device: register file, receive fifo, overrun tally
	assign reg_rdata = reg_val(reg_addr);
	assign fifo_rdata = fifo_val(fcnt);
	always @(posedge ref_clk_i)
	begin
		if (fifo_pop)
			fcnt <= fcnt + 1;
		if (overrun)
			ov_cnt++;
	end
	// every register read or write handed to user logic has its target kind checked; ordinary writes also have their address checked
	always @(posedge ref_clk_i)
	begin
		if (reg_rd || reg_wr)
			chk_bit(acc_fifo, exp_fifo);
		if ((reg_rd || reg_wr) && acc_fifo)
			chk_bit(reg_addr[6:2] == 5'h00, 1'b1);
		if (reg_wr)
			chk_data(reg_wdata, exp_wdata);
		if (reg_wr && !exp_fifo)
			chk_data({25'h0, reg_addr}, {25'h0, exp_addr});
		if (reg_wr)
			n_wr++;
	end

	// free-running clock, 8 ns period
	always #4 ref_clk_i = ~ref_clk_i;
	// hang guard
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		n_mismatch++;
		stop_test();
	end
	// corner cases first, then random traffic
	initial
	begin
		logic [31:0] r;
		repeat (20) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		run(1'b0, 1'b0, 7'h02, 8'd0, 32'h0);
		run(1'b0, 1'b0, 7'h10, 8'd8, 32'h0);
		run(1'b0, 1'b0, 7'h20, 8'd9, 32'h0);
		run(1'b1, 1'b0, 7'h12, 8'd1, 32'hdead_beef);
		run(1'b0, 1'b1, 7'h7e, 8'd30, 32'h0);
		bus16 <= 1'b1;
		run(1'b0, 1'b0, 7'h05, 8'd16, 32'h0);
		run(1'b0, 1'b0, 7'h31, 8'd17, 32'h0);
		run(1'b1, 1'b0, 7'h13, 8'd1, 32'hcafe_f00d);
		run(1'b0, 1'b1, 7'h7f, 8'd20, 32'h0);
		run(1'b1, 1'b1, 7'h44, 8'd1, 32'h1234_5678);
		repeat (40)
		begin
			r = rnd();
			bus16 <= r[0];
			@(posedge ref_clk_i);
			run(r[1] & r[2], r[3], r[0] ? r[20:14] : {r[20:15], 1'b0},
				r[1] & r[2] ? 8'd1 : (r[3] ? 8'(r[12:8] % 24 + 1) :
				8'(r[11:8] % (r[0] ? 16 : 8) + 1)), rnd());
		end
		stop_test();
	end
endmodule
